/* File: ccr_regs.svh */
// Register selects, field positions, reset values and fixed capability values of the configuration bank
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// Register selects within the configuration register number
`define CCR_SEL_BASE 3'h0
`define CCR_SEL_GEOM 3'h1
`define CCR_SEL_OUTER 3'h2
`define CCR_SEL_EXT 3'h3
`define CCR_SEL_IMPL 3'h6

// core_config_base fields
`define CCR_BASE_CONT_BIT 31
`define CCR_BASE_BURST_BIT 16
`define CCR_BASE_ENDIAN_BIT 15
`define CCR_BASE_ISAW_LSB 13
`define CCR_BASE_REL_LSB 10
`define CCR_BASE_MMU_LSB 7
`define CCR_BASE_VI_BIT 3
`define CCR_BASE_K0_LSB 0
`define CCR_K0_RESET 3'h2
`define CCR_ISA_WIDTH_32 2'h0
`define CCR_ISA_RELEASE_TWO 3'h1

// cache_geometry_cfg fields
`define CCR_GEOM_TLB_LSB 25
`define CCR_GEOM_IS_LSB 22
`define CCR_GEOM_IL_LSB 19
`define CCR_GEOM_IA_LSB 16
`define CCR_GEOM_DS_LSB 13
`define CCR_GEOM_DL_LSB 10
`define CCR_GEOM_DA_LSB 7
`define CCR_GEOM_C2_BIT 6
`define CCR_GEOM_PC_BIT 4
`define CCR_GEOM_WR_BIT 3
`define CCR_GEOM_CA_BIT 2
`define CCR_GEOM_EP_BIT 1
`define CCR_GEOM_FP_BIT 0

// outer_cache_cfg fields
`define CCR_OUT_TU_LSB 28
`define CCR_OUT_TS_LSB 24
`define CCR_OUT_TL_LSB 20
`define CCR_OUT_TA_LSB 16
`define CCR_OUT_SU_LSB 13
`define CCR_OUT_L2B_BIT 12
`define CCR_OUT_SS_LSB 8
`define CCR_OUT_SL_LSB 4
`define CCR_OUT_SA_LSB 0

// extension_caps fields
`define CCR_EXT_COHERENCE_REGS_PRESENT_BIT 29
`define CCR_EXT_USER_LOCAL_PRESENT_BIT 13
`define CCR_EXT_DSP2_BIT 11
`define CCR_EXT_DSP_BIT 10
`define CCR_EXT_CTXT_BIT 9
`define CCR_EXT_EIC_BIT 6
`define CCR_EXT_VECTORED_IRQ_CAPABLE_BIT 5
`define CCR_EXT_SP_BIT 4
`define CCR_EXT_DEVICE_MAP_SUPPORT_BIT 3
`define CCR_EXT_SM_BIT 1
`define CCR_EXT_TRACE_BIT 0

// impl_options_cfg fields
`define CCR_IMPL_JUMP_PREDICT_ENABLE_BIT 5
`define CCR_IMPL_JRCP_BIT 4
`define CCR_IMPL_TLB_RECENT_REPLACE_DISABLE_BIT 3
`define CCR_IMPL_NMRUP_BIT 2
`define CCR_IMPL_SYNONYM_UPDATE_DISABLE_BIT 1
`define CCR_IMPL_PERF_CLK_GATE_DISABLE_BIT 0

`endif

/* File: ccr_pkg.sv */
// Types shared by the configuration register bank
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_MMU_TLB = 2'h1,
    CCR_MMU_FIXED = 2'h3
  } ccr_mmu_e;
  typedef logic [2:0] ccr_sel_t;
endpackage

/* File: ccr_config_bank.sv */
// Processor configuration and capability register bank, reached as coprocessor-0 registers
// Summary of operation
// - Burst-order field is read-only hardware strap
// - Endian flag reads 1 big, 0 little
// - ISA width kind reads 0 here
// - Architecture release field reads 1 here
// - MMU kind reports TLB or fixed mapping
// - Virtual icache flag only if VA-indexed-and-tagged
// - Kseg0 attribute steers kseg0 caching
// - Continuation bits 1,1,1 then 0 in extensions
// - TLB size field holds entries minus one
// - Cache geometry codes: sets, line, ways
// - Coprocessor, FPU, counter presence bits reflect fit
// - Watchpoint, compressed ISA, debug always read 1
// - Bypass forces secondary line code to 0
// - Bypass write drives L2; read returns feedback
// - Outer cache codes share level-one encoding
// - Outer implementation bits may be writable
// - Coherence presence bit reflects its option
// - Signal extension bit, revision two also 1
// - User-local, context, trace bits reflect options
// - External irq controller bit mirrors input pin
// - Vectored reads 1; page, map, crypto 0
// - Option register: counter clock, synonym, TLB, jump
// - Kseg0 attribute is three bits wide
// - Kseg0 attribute resets to 2, uncached
`timescale 1ns/1ns
`include "ccr_regs.svh"

module ccr_config_bank #(
  parameter bit BIG_ENDIAN = 1'b0,
  parameter bit BURST_SUBBLOCK = 1'b0,
  parameter ccr_pkg::ccr_mmu_e MMU_KIND = ccr_pkg::CCR_MMU_TLB,
  parameter bit ICACHE_VIRTUAL = 1'b0,
  parameter int TLB_ENTRIES = 32,
  parameter logic [2:0] IC_SETS = 3'h2,
  parameter logic [2:0] IC_LINE = 3'h4,
  parameter logic [2:0] IC_WAYS = 3'h3,
  parameter logic [2:0] DC_SETS = 3'h2,
  parameter logic [2:0] DC_LINE = 3'h4,
  parameter logic [2:0] DC_WAYS = 3'h3,
  parameter logic [3:0] L2_SETS = 4'h0,
  parameter logic [3:0] L2_LINE = 4'h0,
  parameter logic [3:0] L2_WAYS = 4'h0,
  parameter logic [3:0] L3_SETS = 4'h0,
  parameter logic [3:0] L3_LINE = 4'h0,
  parameter logic [3:0] L3_WAYS = 4'h0,
  parameter logic [2:0] L2_IMPL_RESET = 3'h0,
  parameter logic [3:0] L3_IMPL_RESET = 4'h0,
  parameter bit COP2_FITTED = 1'b0,
  parameter bit FPU_FITTED = 1'b0,
  parameter bit PERF_COUNTERS = 1'b1,
  parameter bit COHERENCE_REGS = 1'b0,
  parameter bit USER_LOCAL = 1'b1,
  parameter bit SIGNAL_EXT = 1'b1,
  parameter bit CONTEXT_CONFIG = 1'b1,
  parameter bit TRACE_FITTED = 1'b0,
  parameter bit TLB_RECENT_FITTED = 1'b1,
  parameter bit JUMP_CACHE_FITTED = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Coprocessor register access
  input wire logic cfg_wr_en,
  input wire ccr_pkg::ccr_sel_t cfg_sel,
  input wire logic [31:0] cfg_wr_data,
  output logic [31:0] cfg_rd_data,
  // Pins from the system
  input wire logic ext_irq_ctrl_input,
  input wire logic outer_bypass_fb,
  // Controls to the core and L2
  output logic outer_bypass,
  output logic [2:0] kseg_zero_cache_attr,
  output logic perf_clk_gate_disable,
  output logic synonym_update_disable,
  output logic tlb_recent_replace_disable,
  output logic jump_predict_enable
);

  // Fixed codes derived from build options
  localparam logic [5:0] TLB_SIZE_CODE = 6'(TLB_ENTRIES - 1);

  // Writable state, one register per field
  logic [2:0] k0_reg;
  logic bypass_reg;
  logic [2:0] l2_impl_reg;
  logic [2:0] l3_impl_reg;
  logic perf_clk_gate_disable_reg;
  logic synonym_update_disable_reg;
  logic tlb_recent_replace_disable_reg;
  logic jump_predict_enable_reg;

  // Write strobes, one per writable register
  logic wr_base;
  logic wr_outer;
  logic wr_impl;

  // Base word fields
  logic burst_order_flag;
  logic endian_flag;
  logic [1:0] isa_width_kind;
  logic [2:0] isa_release_level;
  logic [2:0] mmu_kind;
  logic icache_uses_va;

  // Geometry word fields
  logic [5:0] tlb_entries_minus_one;
  logic [2:0] icache_sets_code;
  logic [2:0] icache_line_code;
  logic [2:0] icache_ways_code;
  logic [2:0] dcache_sets_code;
  logic [2:0] dcache_line_code;
  logic [2:0] dcache_ways_code;
  logic cop_two_present;
  logic perf_counter_present;
  logic watch_regs_present;
  logic compressed_isa_present;
  logic debug_unit_present;
  logic float_unit_present;

  // Outer cache word fields
  logic [2:0] l3_impl_bits;
  logic [3:0] l3_sets_code;
  logic [3:0] l3_line_code;
  logic [3:0] l3_ways_code;
  logic [2:0] l2_impl_bits;
  logic l2_bypass_seen;
  logic [3:0] l2_sets_code;
  logic [3:0] l2_line_code;
  logic [3:0] l2_ways_code;

  // Extension word fields
  logic coherence_regs_present;
  logic user_local_present;
  logic signal_ext_rev_two;
  logic signal_ext_present;
  logic context_config_present;
  logic ext_irq_ctrl_present;
  logic vectored_irq_capable;
  logic small_page_support;
  logic device_map_support;
  logic alt_crypto_ext_support;
  logic trace_present;

  // Option word presence fields
  logic tlb_recent_present;
  logic jump_cache_present;

  // Assembled words and read selection
  logic [31:0] base_word;
  logic [31:0] geom_word;
  logic [31:0] outer_word;
  logic [31:0] ext_word;
  logic [31:0] impl_word;
  logic [31:0] rd_next;

  // A write needs its strobe and a matching select in one cycle
  assign wr_base = cfg_wr_en && (cfg_sel == `CCR_SEL_BASE);
  assign wr_outer = cfg_wr_en && (cfg_sel == `CCR_SEL_OUTER);
  assign wr_impl = cfg_wr_en && (cfg_sel == `CCR_SEL_IMPL);

  // Kseg0 comes up uncached until boot code rewrites it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      k0_reg <= `CCR_K0_RESET;
    end else if (wr_base) begin
      k0_reg <= cfg_wr_data[`CCR_BASE_K0_LSB +: 3];
    end
  end

  // Drives the L2 and masks the secondary line code; the read bypass bit shows the L2's feedback instead
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_reg <= 1'b0;
    end else if (wr_outer) begin
      bypass_reg <= cfg_wr_data[`CCR_OUT_L2B_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      l2_impl_reg <= L2_IMPL_RESET;
    end else if (wr_outer) begin
      l2_impl_reg <= cfg_wr_data[`CCR_OUT_SU_LSB +: 3];
    end
  end

  // Tertiary field has three bits of room, so the top parameter bit is dropped
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      l3_impl_reg <= L3_IMPL_RESET[2:0];
    end else if (wr_outer) begin
      l3_impl_reg <= cfg_wr_data[`CCR_OUT_TU_LSB +: 3];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      perf_clk_gate_disable_reg <= 1'b0;
    end else if (wr_impl) begin
      perf_clk_gate_disable_reg <= cfg_wr_data[`CCR_IMPL_PERF_CLK_GATE_DISABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      synonym_update_disable_reg <= 1'b0;
    end else if (wr_impl) begin
      synonym_update_disable_reg <= cfg_wr_data[`CCR_IMPL_SYNONYM_UPDATE_DISABLE_BIT];
    end
  end

  // The TLB disable and the jump enable only stick when their feature is fitted
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tlb_recent_replace_disable_reg <= 1'b0;
    end else if (wr_impl) begin
      tlb_recent_replace_disable_reg <= cfg_wr_data[`CCR_IMPL_TLB_RECENT_REPLACE_DISABLE_BIT] & TLB_RECENT_FITTED;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      jump_predict_enable_reg <= 1'b0;
    end else if (wr_impl) begin
      jump_predict_enable_reg <= cfg_wr_data[`CCR_IMPL_JUMP_PREDICT_ENABLE_BIT] & JUMP_CACHE_FITTED;
    end
  end

  // Base word fields
  assign burst_order_flag = BURST_SUBBLOCK;
  assign endian_flag = BIG_ENDIAN;
  assign isa_width_kind = `CCR_ISA_WIDTH_32;
  assign isa_release_level = `CCR_ISA_RELEASE_TWO;
  assign mmu_kind = {1'b0, MMU_KIND};
  assign icache_uses_va = ICACHE_VIRTUAL;

  // Geometry word fields
  assign tlb_entries_minus_one = TLB_SIZE_CODE;
  assign icache_sets_code = IC_SETS;
  assign icache_line_code = IC_LINE;
  assign icache_ways_code = IC_WAYS;
  assign dcache_sets_code = DC_SETS;
  assign dcache_line_code = DC_LINE;
  assign dcache_ways_code = DC_WAYS;
  assign cop_two_present = COP2_FITTED;
  assign perf_counter_present = PERF_COUNTERS;
  assign float_unit_present = FPU_FITTED;
  assign watch_regs_present = 1'b1;
  assign compressed_isa_present = 1'b1;
  assign debug_unit_present = 1'b1;

  // Outer cache word fields
  assign l3_impl_bits = l3_impl_reg;
  assign l3_sets_code = L3_SETS;
  assign l3_line_code = L3_LINE;
  assign l3_ways_code = L3_WAYS;
  assign l2_impl_bits = l2_impl_reg;
  assign l2_bypass_seen = outer_bypass_fb;
  assign l2_sets_code = L2_SETS;
  // Follows the written bypass, not the slow feedback, so it hides at once
  assign l2_line_code = bypass_reg ? 4'h0 : L2_LINE;
  assign l2_ways_code = L2_WAYS;

  // Extension word fields
  assign coherence_regs_present = COHERENCE_REGS;
  assign user_local_present = USER_LOCAL;
  assign signal_ext_present = SIGNAL_EXT;
  assign signal_ext_rev_two = SIGNAL_EXT;
  assign context_config_present = CONTEXT_CONFIG;
  assign trace_present = TRACE_FITTED;
  assign ext_irq_ctrl_present = ext_irq_ctrl_input;
  assign vectored_irq_capable = 1'b1;
  assign small_page_support = 1'b0;
  assign device_map_support = 1'b0;
  assign alt_crypto_ext_support = 1'b0;

  // Option word presence fields
  assign tlb_recent_present = TLB_RECENT_FITTED;
  assign jump_cache_present = JUMP_CACHE_FITTED;

  always_comb begin
    base_word = 32'h0;
    base_word[`CCR_BASE_CONT_BIT] = 1'b1;
    base_word[`CCR_BASE_BURST_BIT] = burst_order_flag;
    base_word[`CCR_BASE_ENDIAN_BIT] = endian_flag;
    base_word[`CCR_BASE_ISAW_LSB +: 2] = isa_width_kind;
    base_word[`CCR_BASE_REL_LSB +: 3] = isa_release_level;
    base_word[`CCR_BASE_MMU_LSB +: 3] = mmu_kind;
    base_word[`CCR_BASE_VI_BIT] = icache_uses_va;
    base_word[`CCR_BASE_K0_LSB +: 3] = k0_reg;
  end

  always_comb begin
    geom_word = 32'h0;
    geom_word[`CCR_BASE_CONT_BIT] = 1'b1;
    geom_word[`CCR_GEOM_TLB_LSB +: 6] = tlb_entries_minus_one;
    geom_word[`CCR_GEOM_IS_LSB +: 3] = icache_sets_code;
    geom_word[`CCR_GEOM_IL_LSB +: 3] = icache_line_code;
    geom_word[`CCR_GEOM_IA_LSB +: 3] = icache_ways_code;
    geom_word[`CCR_GEOM_DS_LSB +: 3] = dcache_sets_code;
    geom_word[`CCR_GEOM_DL_LSB +: 3] = dcache_line_code;
    geom_word[`CCR_GEOM_DA_LSB +: 3] = dcache_ways_code;
    geom_word[`CCR_GEOM_C2_BIT] = cop_two_present;
    geom_word[`CCR_GEOM_PC_BIT] = perf_counter_present;
    geom_word[`CCR_GEOM_FP_BIT] = float_unit_present;
    geom_word[`CCR_GEOM_WR_BIT] = watch_regs_present;
    geom_word[`CCR_GEOM_CA_BIT] = compressed_isa_present;
    geom_word[`CCR_GEOM_EP_BIT] = debug_unit_present;
  end

  always_comb begin
    outer_word = 32'h0;
    outer_word[`CCR_BASE_CONT_BIT] = 1'b1;
    outer_word[`CCR_OUT_TU_LSB +: 3] = l3_impl_bits;
    outer_word[`CCR_OUT_TS_LSB +: 4] = l3_sets_code;
    outer_word[`CCR_OUT_TL_LSB +: 4] = l3_line_code;
    outer_word[`CCR_OUT_TA_LSB +: 4] = l3_ways_code;
    outer_word[`CCR_OUT_SU_LSB +: 3] = l2_impl_bits;
    outer_word[`CCR_OUT_L2B_BIT] = l2_bypass_seen;
    outer_word[`CCR_OUT_SS_LSB +: 4] = l2_sets_code;
    outer_word[`CCR_OUT_SL_LSB +: 4] = l2_line_code;
    outer_word[`CCR_OUT_SA_LSB +: 4] = l2_ways_code;
  end

  // Top bit stays 0: no further register follows
  always_comb begin
    ext_word = 32'h0;
    ext_word[`CCR_EXT_COHERENCE_REGS_PRESENT_BIT] = coherence_regs_present;
    ext_word[`CCR_EXT_USER_LOCAL_PRESENT_BIT] = user_local_present;
    ext_word[`CCR_EXT_DSP_BIT] = signal_ext_present;
    ext_word[`CCR_EXT_DSP2_BIT] = signal_ext_rev_two;
    ext_word[`CCR_EXT_CTXT_BIT] = context_config_present;
    ext_word[`CCR_EXT_TRACE_BIT] = trace_present;
    ext_word[`CCR_EXT_EIC_BIT] = ext_irq_ctrl_present;
    ext_word[`CCR_EXT_VECTORED_IRQ_CAPABLE_BIT] = vectored_irq_capable;
    ext_word[`CCR_EXT_SP_BIT] = small_page_support;
    ext_word[`CCR_EXT_DEVICE_MAP_SUPPORT_BIT] = device_map_support;
    ext_word[`CCR_EXT_SM_BIT] = alt_crypto_ext_support;
  end

  always_comb begin
    impl_word = 32'h0;
    impl_word[`CCR_IMPL_PERF_CLK_GATE_DISABLE_BIT] = perf_clk_gate_disable_reg;
    impl_word[`CCR_IMPL_SYNONYM_UPDATE_DISABLE_BIT] = synonym_update_disable_reg;
    impl_word[`CCR_IMPL_NMRUP_BIT] = tlb_recent_present;
    impl_word[`CCR_IMPL_TLB_RECENT_REPLACE_DISABLE_BIT] = tlb_recent_replace_disable_reg;
    impl_word[`CCR_IMPL_JRCP_BIT] = jump_cache_present;
    impl_word[`CCR_IMPL_JUMP_PREDICT_ENABLE_BIT] = jump_predict_enable_reg;
  end

  // Unmapped selects read as zero
  always_comb begin
    if (cfg_sel == `CCR_SEL_BASE) begin
      rd_next = base_word;
    end else if (cfg_sel == `CCR_SEL_GEOM) begin
      rd_next = geom_word;
    end else if (cfg_sel == `CCR_SEL_OUTER) begin
      rd_next = outer_word;
    end else if (cfg_sel == `CCR_SEL_EXT) begin
      rd_next = ext_word;
    end else if (cfg_sel == `CCR_SEL_IMPL) begin
      rd_next = impl_word;
    end else begin
      rd_next = 32'h0;
    end
  end

  // Registered read keeps the data output off combinational paths
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rd_data <= 32'h0;
    end else begin
      cfg_rd_data <= rd_next;
    end
  end

  assign kseg_zero_cache_attr = k0_reg;
  assign outer_bypass = bypass_reg;
  assign perf_clk_gate_disable = perf_clk_gate_disable_reg;
  assign synonym_update_disable = synonym_update_disable_reg;
  assign tlb_recent_replace_disable = tlb_recent_replace_disable_reg;
  assign jump_predict_enable = jump_predict_enable_reg;

endmodule

/* File: ccr_config_bank_sva.sv */
// Port-level assertions for the configuration register bank
`timescale 1ns/1ns
module ccr_config_bank_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register access
  input wire logic cfg_wr_en,
  input wire ccr_pkg::ccr_sel_t cfg_sel,
  input wire logic [31:0] cfg_wr_data,
  input wire logic [31:0] cfg_rd_data,
  // Pins and controls
  input wire logic ext_irq_ctrl_input,
  input wire logic outer_bypass_fb,
  input wire logic outer_bypass,
  input wire logic [2:0] kseg_zero_cache_attr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Same-edge writes excluded; the read word still shows the control from before the write edge
  AST_BASE: assert property (!$past(sys_rst) && !$past(cfg_wr_en) && $past(cfg_sel) == 3'h0 |->
    cfg_rd_data[31] && cfg_rd_data[14:10] == 5'h01 && cfg_rd_data[2:0] == $past(kseg_zero_cache_attr))
    else $error("base word wrong");
  AST_GEOM: assert property (!$past(sys_rst) && $past(cfg_sel) == 3'h1 |->
    cfg_rd_data[31] && cfg_rd_data[3:1] == 3'h7) else $error("geometry word wrong");
  AST_OUTER: assert property (!$past(sys_rst) && !$past(cfg_wr_en) && $past(cfg_sel) == 3'h2 |->
    cfg_rd_data[31] && cfg_rd_data[12] == $past(outer_bypass_fb) && (!$past(outer_bypass) || cfg_rd_data[7:4] == 4'h0))
    else $error("outer word wrong");
  AST_EXT: assert property (!$past(sys_rst) && $past(cfg_sel) == 3'h3 |->
    !cfg_rd_data[31] && cfg_rd_data[6] == $past(ext_irq_ctrl_input) && cfg_rd_data[5:3] == 3'h4
    && !cfg_rd_data[1] && (!cfg_rd_data[10] || cfg_rd_data[11])) else $error("extension word wrong");
  AST_K0_WRITE: assert property (cfg_wr_en && cfg_sel == 3'h0 |=>
    kseg_zero_cache_attr == $past(cfg_wr_data[2:0])) else $error("kseg0 attribute not written");
  AST_K0_HOLD: assert property (!(cfg_wr_en && cfg_sel == 3'h0) |=> $stable(kseg_zero_cache_attr))
    else $error("kseg0 attribute changed");
  AST_K0_RESET: assert property ($past(sys_rst) |-> kseg_zero_cache_attr == 3'h2)
    else $error("kseg0 reset value wrong");
  AST_BYPASS: assert property (cfg_wr_en && cfg_sel == 3'h2 |=> outer_bypass == $past(cfg_wr_data[12]))
    else $error("bypass not driven");
endmodule

bind ccr_config_bank ccr_config_bank_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en),
  .cfg_sel(cfg_sel), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .ext_irq_ctrl_input(ext_irq_ctrl_input),
  .outer_bypass_fb(outer_bypass_fb), .outer_bypass(outer_bypass), .kseg_zero_cache_attr(kseg_zero_cache_attr));

/* File: ccr_config_bank_bench.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
module ccr_config_bank_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_wr_en = 1'b0;
  ccr_pkg::ccr_sel_t cfg_sel = 3'h0;
  logic [31:0] cfg_wr_data = 32'h0;
  logic [31:0] cfg_rd_data;
  logic ext_irq_ctrl_input = 1'b0;
  logic outer_bypass_fb = 1'b0;
  logic outer_bypass, perf_clk_gate_disable, synonym_update_disable;
  logic tlb_recent_replace_disable, jump_predict_enable;
  logic [2:0] kseg_zero_cache_attr;
  logic rd_req = 1'b0;
  logic arm_reg = 1'b0;
  logic [82:0] notes[$];
  logic [82:0] n;
  logic [39:0] seen;
  logic [31:0] d;
  int err_count = 0;
  int total_checks = 0;
  localparam logic [79:0] BASE = {8'h02, 32'h8000_8482, 8'hFF, 32'h8001_FF8F};
  localparam logic [79:0] GEOM = {8'h00, 32'h9EA3_519F, 8'h00, 32'hFFFF_FFDF};
  localparam logic [39:0] FULL = {8'h00, 32'hFFFF_FFFF};
  assign seen = {jump_predict_enable, tlb_recent_replace_disable, synonym_update_disable, perf_clk_gate_disable,
    outer_bypass, kseg_zero_cache_attr, cfg_rd_data};
  ccr_config_bank #(.BIG_ENDIAN(1'b1), .TLB_ENTRIES(16), .L2_SETS(4'h3), .L2_LINE(4'h5), .L2_WAYS(4'h7),
    .FPU_FITTED(1'b1)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en), .cfg_sel(cfg_sel),
    .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data), .ext_irq_ctrl_input(ext_irq_ctrl_input),
    .outer_bypass_fb(outer_bypass_fb), .outer_bypass(outer_bypass), .kseg_zero_cache_attr(kseg_zero_cache_attr),
    .perf_clk_gate_disable(perf_clk_gate_disable), .synonym_update_disable(synonym_update_disable),
    .tlb_recent_replace_disable(tlb_recent_replace_disable), .jump_predict_enable(jump_predict_enable));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) arm_reg <= rd_req;
  // Falling edge: read word of the last edge has settled
  always @(negedge clk_sys) begin
    if (arm_reg && notes.size() > 0) begin
      n = notes.pop_front();
      total_checks++;
      if (((seen ^ n[79:40]) & n[39:0]) !== 40'h0) begin
        err_count++;
        $display("MISMATCH sel %0d expected %h seen %h", n[82:80], n[79:40], seen & n[39:0]);
      end
    end
  end
  task automatic op(input logic w, input logic [2:0] s, input logic [31:0] wd, input logic [79:0] em);
    cfg_wr_en = w;
    cfg_sel = s;
    cfg_wr_data = wd;
    rd_req = !w;
    if (!w) notes.push_back({s, em});
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [2:0] s, input logic [79:0] em);
    op(1'b0, s, 32'h0, em);
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] wd);
    op(1'b1, s, wd, 80'h0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4512));
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rd(3'h0, BASE);
    rd(3'h1, GEOM);
    rd(3'h2, {8'h00, 32'h8000_0357, FULL});
    for (int i = 0; i < 4; i++) begin
      ext_irq_ctrl_input = i[0];
      rd(3'h3, {8'h00, 32'h0000_2E20 | {25'h0, i[0], 6'h0}, 8'h00, 32'hA000_2E7B});
    end
    $display("test fixed words done");
    // Read-only and unmapped words shrug off writes
    wr(3'h1, 32'hFFFF_FFFF);
    wr(3'h3, 32'hFFFF_FFFF);
    wr(3'h4, 32'hFFFF_FFFF);
    rd(3'h1, GEOM);
    rd(3'h3, {8'h00, 32'h0000_2E60, 8'h00, 32'hA000_2E7B});
    rd(3'h4, {40'h0, FULL});
    rd(3'h5, {40'h0, FULL});
    rd(3'h7, {40'h0, FULL});
    $display("test read-only done");
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      d[2:0] = 3'(k);
      wr(3'h0, d);
      rd(3'h0, {5'h00, 3'(k), 32'h8000_8480 | 32'(k), BASE[39:0]});
    end
    $display("test kseg0 done");
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      wr(3'h6, d);
      rd(3'h6, {d[5], d[3], d[1], d[0], 30'h0, d[5], 1'b1, d[3], 1'b1, d[1], d[0], 8'hF0, 32'h3F});
    end
    $display("test options done");
    // Feedback lags the written bypass; read bypass bit follows feedback, line code follows the write
    wr(3'h2, 32'hFFFF_FFFF);
    rd(3'h2, {8'h08, 32'hF000_E307, 8'h08, 32'hFFFF_FFFF});
    outer_bypass_fb = 1'b1;
    rd(3'h2, {8'h08, 32'hF000_F307, 8'h08, 32'hFFFF_FFFF});
    wr(3'h2, 32'h0);
    rd(3'h2, {8'h00, 32'h8000_1357, 8'h08, 32'hFFFF_FFFF});
    outer_bypass_fb = 1'b0;
    rd(3'h2, {8'h00, 32'h8000_0357, 8'h08, 32'hFFFF_FFFF});
    $display("test bypass done");
    rd_req = 1'b0;
    @(posedge clk_sys);
    #1;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    rd(3'h0, BASE);
    $display("test second reset done");
    rd_req = 1'b0;
    @(posedge clk_sys);
    #1;
    end_of_test;
  end
endmodule
